// [design/ipl_adc_front.sv]
// Converter clock divider and decimation filters for both coil channels.
`timescale 1ns/1ps
module ipl_adc_front (
  input  wire logic sys_clk,
  input  wire logic nrst,
  input  wire logic coilInputA,
  input  wire logic coilInputB,
  ipl_adc_if.front  adc
);
  typedef struct packed {
    logic [5:0]  divCnt;
    logic        adcClk;
    logic [6:0]  decCnt;
    logic [7:0]  accA;
    logic [7:0]  accB;
    logic [11:0] prevA;
    logic [11:0] prevB;
    logic [11:0] sinS;
    logic [11:0] cosS;
    logic        valid;
  } ipl_front_t;

  ipl_front_t st;
  ipl_front_t next_st;
  logic       adcTick;
  logic [5:0] divLast;

  // Saturates a ones count to a 12-bit code; the 13-bit top value becomes FFF.
  function automatic logic [11:0] toCode(input logic [7:0] ones);
    logic [12:0] full;
    full = {ones[7:0], 5'h00};
    toCode = full[12] ? 12'hFFF : full[11:0];
  endfunction

  // Divider terminal count from the rate code: 7, 15, 31 or 63, a period of 8, 16, 32 or 64 cycles.
  assign divLast = 6'((1 << (ipl_pkg::DIV_BASE_LOG + adc.rate)) - 1);
  assign adcTick = (st.divCnt == divLast);

  // Count modulator ones per window, then filter and hand the sample on.
  always_comb begin
    logic [11:0] a;
    logic [11:0] b;
    logic [13:0] fa;
    logic [13:0] fb;
    next_st = st;
    a = toCode(st.accA);
    b = toCode(st.accB);
    fa = 14'(a) + 14'(st.prevA);
    fb = 14'(b) + 14'(st.prevB);
    next_st.valid = 1'b0;
    next_st.divCnt = adcTick ? 6'h00 : st.divCnt + 6'h01;
    if (st.divCnt == {1'b0, divLast[5:1]} || adcTick) begin
      next_st.adcClk = ~st.adcClk;
    end
    if (adcTick) begin
      next_st.decCnt = st.decCnt + 7'h01;
      next_st.accA = st.accA + 8'(coilInputA);
      next_st.accB = st.accB + 8'(coilInputB);
      if (st.decCnt == 7'h7F) begin
        // Sinc window closes; the half-band stage averages two windows.
        next_st.accA = 8'(coilInputA);
        next_st.accB = 8'(coilInputB);
        next_st.prevA = a;
        next_st.prevB = b;
        if (adc.firEn) begin
          a = fa[12:1];
          b = fb[12:1];
        end
        next_st.sinS = adc.swap ? a : b;
        next_st.cosS = adc.swap ? b : a;
        next_st.valid = 1'b1;
      end
    end
  end

  // State register.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign adc.sinSample   = st.sinS;
  assign adc.cosSample   = st.cosS;
  assign adc.sampleValid = st.valid;
  assign adc.adcClk      = st.adcClk;

  a_tick_rate_eight: assert property (@(posedge sys_clk) disable iff (!nrst)
    (adcTick && adc.rate == 2'b00) ##1 (adc.rate == 2'b00) [*8] |-> adcTick)
    else $error("Converter tick spacing wrong at divide by eight.");
endmodule

// [design/ipl_adc_if.sv]
// Link between the converter front end and the processing core.
`timescale 1ns/1ps
interface ipl_adc_if;
  logic [1:0]  rate;
  logic        firEn;
  logic        swap;
  logic [11:0] sinSample;
  logic [11:0] cosSample;
  logic        sampleValid;
  logic        adcClk;
  modport front (input rate, firEn, swap, output sinSample, cosSample, sampleValid, adcClk);
  modport core  (output rate, firEn, swap, input sinSample, cosSample, sampleValid, adcClk);
endinterface

// [design/ipl_linearizer.sv]
// Top of the position linearizer: registers, correction, interpolation, outputs.
`timescale 1ns/1ps
// Functional notes
// - Amplitude max scaled by four limits input.
// - Origin doubled shifts position, not output.
// - High clamp is 8*(code+1)-1.
// - Low clamp is 8*(code-1), floor zero.
// - Low clamp wins when clamps cross.
// - Separate end slopes before first, after fifth.
// - Points one, three, five doubled from storage.
// - Point two is midpoint plus doubled adjust.
// - Point four is midpoint plus doubled adjust.
// - Swap bit picks which coil is sine.
// - Gain trim top bit adds minus 24, zero default.
// - Feedback radius bit, reset value one.
// - Carrier amplitude fault forces output zero.
// - Trim bits add 6, 12, minus 24 percent.
// - Converter clock divided by 8 to 64.
// - Sinc stage plus optional half-band stage.
// - Converter results kept as 12-bit values.
// - Filter bit selects sinc or sinc plus FIR.
// - PWM period equals the sample update period.
module ipl_linearizer (
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        coilInputA,
  input  wire logic        coilInputB,
  input  wire logic        carrierOver,
  input  wire logic        carrierUnder,
  output logic      [12:0] analogPositionOut,
  output logic             pwmOut,
  output logic             faultOut,
  output logic      [2:0]  pgaTrim,
  output logic      [5:0]  gainDeltaPct,
  output logic             fbkRadiusSel,
  output logic             adcClkOut
);
  typedef struct packed {
    logic                swap;
    logic [2:0]          gainTrim;
    logic                carrier_feedback_radius;
    logic [1:0]          rate;
    logic                fir;
    logic                loaded;
    logic [7:0]          ampMax;
    logic [11:0]         origin;
    logic [11:0]         x1;
    logic [11:0]         y1;
    logic [11:0]         x3;
    logic [11:0]         y3;
    logic [11:0]         x5;
    logic [11:0]         y5;
    logic [5:0]          adj2;
    logic [5:0]          adj4;
    logic [11:0]         slope0;
    logic [11:0]         slope5;
    logic [9:0]          loClamp;
    logic [9:0]          hiClamp;
    ipl_pkg::ipl_state_t state;
    logic signed [15:0]  yBase;
    logic [31:0]         quot;
    logic [16:0]         rem;
    logic [15:0]         den;
    logic                neg;
    logic [4:0]          cnt;
    logic [12:0]         pos;
    logic                upd;
    logic                fault;
    logic [12:0]         pwmCnt;
    logic                pwm;
    logic [5:0]          gainDelta;
    logic                adcClk;
    logic [31:0]         rdata;
    logic                ready;
    logic                err;
  } ipl_core_t;

  ipl_core_t          st;
  ipl_core_t          next_st;
  ipl_adc_if          adc ();
  logic signed [15:0] bx [5];
  logic signed [15:0] by [5];
  logic               apbDone;
  logic               known;
  logic [31:0]        readMux;

  ipl_adc_front u_front (
    .sys_clk   (sys_clk),
    .nrst      (nrst),
    .coilInputA(coilInputA),
    .coilInputB(coilInputB),
    .adc       (adc)
  );

  assign adc.rate  = st.rate;
  assign adc.firEn = st.fir;
  assign adc.swap  = st.swap;

  ////////////////////////////////////////////////////////////////////////////
  // Arithmetic helpers.

  // Stored coordinate doubled to its internal value.
  function automatic logic signed [15:0] dbl(input logic [11:0] v);
    dbl = 16'(v) <<< ipl_pkg::COORD_SHIFT;
  endfunction

  // Sum of two doubled coordinates halved, plus a doubled signed adjust.
  function automatic logic signed [15:0] midY(input logic [11:0] a, input logic [11:0] b,
                                              input logic [5:0] adj);
    midY = 16'(a) + 16'(b) + (16'(signed'(adj)) <<< ipl_pkg::COORD_SHIFT);
  endfunction

  // Apply high clamp, then low clamp so the low one wins when crossed.
  function automatic logic [12:0] clampOut(input logic signed [31:0] v,
                                           input logic [9:0] lo, input logic [9:0] hi);
    logic signed [31:0] hiV;
    logic signed [31:0] loV;
    logic signed [31:0] r;
    hiV = ((32'(hi) + 32'sd1) <<< ipl_pkg::CLAMP_SHIFT) - 32'sd1;
    loV = (32'(lo) - 32'sd1) <<< ipl_pkg::CLAMP_SHIFT;
    r = v;
    if (r > hiV) begin
      r = hiV;
    end
    if (r < loV) begin
      r = loV;
    end
    if (r < 32'sd0) begin
      r = 32'sd0;
    end
    if (r > 32'sd8191) begin
      r = 32'(ipl_pkg::OUT_MAX);
    end
    clampOut = r[12:0];
  endfunction

  // Breakpoint table: three stored points and two derived midpoints.
  always_comb begin
    bx[0] = dbl(st.x1);
    by[0] = dbl(st.y1);
    bx[2] = dbl(st.x3);
    by[2] = dbl(st.y3);
    bx[4] = dbl(st.x5);
    by[4] = dbl(st.y5);
    bx[1] = 16'(st.x1) + 16'(st.x3);
    by[1] = midY(st.y1, st.y3, st.adj2);
    bx[3] = 16'(st.x3) + 16'(st.x5);
    by[3] = midY(st.y3, st.y5, st.adj4);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read decode.

  always_comb begin
    known = 1'b1;
    readMux = 32'h0000_0000;
    case (paddr)
      ipl_pkg::ADDR_CTRL: begin
        readMux[8:0] = {st.loaded, st.fir, st.rate, st.carrier_feedback_radius, st.gainTrim, st.swap};
      end
      ipl_pkg::ADDR_AMPMAX: readMux[7:0] = st.ampMax;
      ipl_pkg::ADDR_ORIGIN: readMux[11:0] = st.origin;
      ipl_pkg::ADDR_BP1: readMux = {4'h0, st.y1, 4'h0, st.x1};
      ipl_pkg::ADDR_BP3: readMux = {4'h0, st.y3, 4'h0, st.x3};
      ipl_pkg::ADDR_BP5: readMux = {4'h0, st.y5, 4'h0, st.x5};
      ipl_pkg::ADDR_ADJ: readMux = {10'h000, st.adj4, 10'h000, st.adj2};
      ipl_pkg::ADDR_SLOPE: readMux = {4'h0, st.slope5, 4'h0, st.slope0};
      ipl_pkg::ADDR_CLAMP: readMux = {6'h00, st.hiClamp, 6'h00, st.loClamp};
      ipl_pkg::ADDR_STATUS: readMux = {3'h0, st.pos, 14'h0000, st.upd, st.fault};
      default: known = 1'b0;
    endcase
  end

  assign apbDone = psel && penable && st.ready;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic: bus slave, correction, interpolation and outputs.

  always_comb begin
    logic signed [15:0] diff;
    logic signed [15:0] lim;
    logic signed [15:0] x;
    logic signed [31:0] prod;
    logic signed [31:0] yv;
    logic [2:0]         seg;
    logic [16:0]        trial;
    logic [12:0]        pwmCmp;
    next_st = st;
    diff = 16'(adc.sinSample) - 16'(adc.cosSample);
    lim = 16'(st.ampMax) <<< ipl_pkg::AMP_SHIFT;
    prod = 32'sd0;
    yv = 32'sd0;
    trial = 17'h00000;
    seg = 3'h0;
    next_st.upd = 1'b0;
    next_st.ready = 1'b0;
    next_st.adcClk = adc.adcClk;
    // Correction: limit by scaled amplitude, then shift the zero point.
    if (diff > lim) begin
      diff = lim;
    end
    if (diff < -lim) begin
      diff = -lim;
    end
    x = diff + 16'(ipl_pkg::MID_CODE) + (16'(st.origin) <<< ipl_pkg::ORIGIN_SHIFT);
    for (int k = 1; k < 4; k++) begin
      if (x >= bx[k]) begin
        seg = 3'(k);
      end
    end
    // Bus slave: one wait-free access phase, errors for unknown offsets.
    if (psel && !penable) begin
      next_st.ready = 1'b1;
      next_st.err = !known || (pwrite && paddr == ipl_pkg::ADDR_STATUS);
      next_st.rdata = known ? readMux : 32'h0000_0000;
    end
    if (apbDone && pwrite && known) begin
      case (paddr)
        ipl_pkg::ADDR_CTRL: begin
          next_st.swap = pwdata[ipl_pkg::CTRL_SWAP];
          next_st.gainTrim = pwdata[ipl_pkg::CTRL_GAIN+:3];
          next_st.carrier_feedback_radius = pwdata[ipl_pkg::CTRL_FBK];
          next_st.rate = pwdata[ipl_pkg::CTRL_RATE+:2];
          next_st.fir = pwdata[ipl_pkg::CTRL_FIR];
          next_st.loaded = pwdata[ipl_pkg::CTRL_LOADED];
        end
        ipl_pkg::ADDR_AMPMAX: next_st.ampMax = pwdata[7:0];
        ipl_pkg::ADDR_ORIGIN: next_st.origin = pwdata[11:0];
        ipl_pkg::ADDR_BP1: {next_st.y1, next_st.x1} = {pwdata[27:16], pwdata[11:0]};
        ipl_pkg::ADDR_BP3: {next_st.y3, next_st.x3} = {pwdata[27:16], pwdata[11:0]};
        ipl_pkg::ADDR_BP5: {next_st.y5, next_st.x5} = {pwdata[27:16], pwdata[11:0]};
        ipl_pkg::ADDR_ADJ: {next_st.adj4, next_st.adj2} = {pwdata[21:16], pwdata[5:0]};
        ipl_pkg::ADDR_SLOPE: begin
          {next_st.slope5, next_st.slope0} = {pwdata[27:16], pwdata[11:0]};
        end
        ipl_pkg::ADDR_CLAMP: begin
          {next_st.hiClamp, next_st.loClamp} = {pwdata[25:16], pwdata[9:0]};
        end
        default: next_st.err = 1'b1;
      endcase
    end
    // Gain trim: bits weigh 6, 12 and minus 24 percent, summed.
    next_st.gainDelta = (st.gainTrim[0] ? ipl_pkg::GAIN_B0 : 6'sh00)
                      + (st.gainTrim[1] ? ipl_pkg::GAIN_B1 : 6'sh00)
                      + (st.gainTrim[2] ? ipl_pkg::GAIN_B2 : 6'sh00);
    // Position pipeline; waits for loaded parameters before any output.
    case (st.state)
      ipl_pkg::ST_IDLE: begin
        if (adc.sampleValid && st.loaded) begin
          if (x < bx[0]) begin
            prod = 32'(x - bx[0]) * 32'(signed'(st.slope0));
            yv = 32'(by[0]) + (prod >>> ipl_pkg::SLOPE_FRAC);
            next_st.pos = clampOut(yv, st.loClamp, st.hiClamp);
            next_st.upd = 1'b1;
          end else if (x > bx[4]) begin
            prod = 32'(x - bx[4]) * 32'(signed'(st.slope5));
            yv = 32'(by[4]) + (prod >>> ipl_pkg::SLOPE_FRAC);
            next_st.pos = clampOut(yv, st.loClamp, st.hiClamp);
            next_st.upd = 1'b1;
          end else begin
            // Inner segment: start a serial divide of dy*dx by the segment width.
            prod = 32'(x - bx[seg]) * 32'(by[seg + 3'h1] - by[seg]);
            next_st.neg = prod[31];
            next_st.quot = prod[31] ? 32'(-prod) : prod;
            next_st.den = 16'(bx[seg + 3'h1] - bx[seg]);
            next_st.yBase = by[seg];
            next_st.rem = 17'h00000;
            next_st.cnt = 5'h1F;
            next_st.state = ipl_pkg::ST_DIV;
          end
        end
      end
      ipl_pkg::ST_DIV: begin
        // Restoring division, one quotient bit per cycle; a zero-width
        // segment yields all ones and is later clamped.
        trial = {st.rem[15:0], st.quot[31]};
        next_st.quot = {st.quot[30:0], 1'b0};
        next_st.rem = trial;
        if (trial >= {1'b0, st.den}) begin
          next_st.rem = trial - {1'b0, st.den};
          next_st.quot[0] = 1'b1;
        end
        next_st.cnt = st.cnt - 5'h01;
        if (st.cnt == 5'h00) begin
          next_st.state = ipl_pkg::ST_OUT;
        end
      end
      ipl_pkg::ST_OUT: begin
        yv = st.neg ? 32'(st.yBase) - st.quot : 32'(st.yBase) + st.quot;
        next_st.pos = clampOut(yv, st.loClamp, st.hiClamp);
        next_st.upd = 1'b1;
        next_st.state = ipl_pkg::ST_IDLE;
      end
      default: next_st.state = ipl_pkg::ST_IDLE;
    endcase
    // Fault and unloaded parameters override any computed position.
    next_st.fault = carrierOver || carrierUnder;
    if (next_st.fault || !st.loaded) begin
      next_st.pos = 13'h0000;
    end
    // PWM restarts on each sample, so its period is the update period.
    next_st.pwmCnt = adc.sampleValid ? 13'h0000 : st.pwmCnt + 13'h0001;
    pwmCmp = 13'(st.pwmCnt << (2'd3 - st.rate));
    next_st.pwm = (pwmCmp < st.pos) && !st.fault;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register with documented power-up values.

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
      st.carrier_feedback_radius <= ipl_pkg::FBK_RESET;
      st.hiClamp <= ipl_pkg::HICLAMP_RST;
      st.loClamp <= ipl_pkg::LOCLAMP_RST;
    end else begin
      st <= next_st;
    end
  end

  assign prdata = st.rdata;
  assign pready = st.ready;
  assign pslverr = st.err;
  assign analogPositionOut = st.pos;
  assign pwmOut = st.pwm;
  assign faultOut = st.fault;
  assign pgaTrim = st.gainTrim;
  assign gainDeltaPct = st.gainDelta;
  assign fbkRadiusSel = st.carrier_feedback_radius;
  assign adcClkOut = st.adcClk;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  a_fault_zero_out: assert property (@(posedge sys_clk) disable iff (!nrst)
    (carrierOver || carrierUnder) |=> (analogPositionOut == 13'h0000) && faultOut)
    else $error("Output not forced to zero on carrier fault.");

  a_unloaded_zero_out: assert property (@(posedge sys_clk) disable iff (!nrst)
    !st.loaded |=> analogPositionOut == 13'h0000)
    else $error("Output moved before parameters were loaded.");

  // The clamps that shaped a result are those of the cycle before the update.
  a_high_clamp_kept: assert property (@(posedge sys_clk) disable iff (!nrst)
    (st.upd && $past(st.loClamp) <= $past(st.hiClamp))
      |-> 32'(analogPositionOut) <= ((32'($past(st.hiClamp)) + 32'd1) << 3) - 32'd1)
    else $error("Output above high clamp.");

  a_low_clamp_kept: assert property (@(posedge sys_clk) disable iff (!nrst)
    (st.upd && !st.fault && $past(st.loClamp) != 10'h000)
      |-> 32'(analogPositionOut) >= (32'($past(st.loClamp)) - 32'd1) << 3)
    else $error("Output below low clamp.");

  a_low_clamp_wins: assert property (@(posedge sys_clk) disable iff (!nrst)
    (st.upd && !st.fault && $past(st.loClamp) > $past(st.hiClamp))
      |-> 32'(analogPositionOut) == (32'($past(st.loClamp)) - 32'd1) << 3)
    else $error("Crossed clamps did not settle on the low clamp.");

  a_gain_trim_delta: assert property (@(posedge sys_clk) disable iff (!nrst)
    (pgaTrim == 3'b101 && $stable(pgaTrim)) |=> gainDeltaPct == 6'h2E)
    else $error("Gain trim percentage wrong.");

  a_fbk_write_taken: assert property (@(posedge sys_clk) disable iff (!nrst)
    (apbDone && pwrite && paddr == ipl_pkg::ADDR_CTRL)
      |=> fbkRadiusSel == $past(pwdata[ipl_pkg::CTRL_FBK]))
    else $error("Feedback radius bit not taken from the write.");

  a_apb_one_wait: assert property (@(posedge sys_clk) disable iff (!nrst)
    (psel && !penable) |=> pready ##1 !pready)
    else $error("Bus answer not exactly one cycle after setup.");

  a_pwm_period: assert property (@(posedge sys_clk) disable iff (!nrst)
    adc.sampleValid |=> st.pwmCnt == 13'h0000)
    else $error("PWM period not restarted on sample update.");
endmodule

// [design/ipl_pkg.sv]
// Shared constants and types of the inductive position linearizer.
package ipl_pkg;
  // Register byte offsets.
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_AMPMAX = 8'h04;
  localparam logic [7:0] ADDR_ORIGIN = 8'h08;
  localparam logic [7:0] ADDR_BP1    = 8'h0C;
  localparam logic [7:0] ADDR_BP3    = 8'h10;
  localparam logic [7:0] ADDR_BP5    = 8'h14;
  localparam logic [7:0] ADDR_ADJ    = 8'h18;
  localparam logic [7:0] ADDR_SLOPE  = 8'h1C;
  localparam logic [7:0] ADDR_CLAMP  = 8'h20;
  localparam logic [7:0] ADDR_STATUS = 8'h24;
  // Control register fields.
  localparam int CTRL_SWAP   = 0;
  localparam int CTRL_GAIN   = 1;
  localparam int CTRL_FBK    = 4;
  localparam int CTRL_RATE   = 5;
  localparam int CTRL_FIR    = 7;
  localparam int CTRL_LOADED = 8;
  // Upper field of the paired registers.
  localparam int HI_FIELD    = 16;
  // Reset values.
  localparam logic       FBK_RESET    = 1'b1;
  localparam logic [9:0] HICLAMP_RST  = 10'h3FF;
  localparam logic [9:0] LOCLAMP_RST  = 10'h001;
  // Arithmetic scale factors as shift counts, plus the output limit and mid code.
  localparam int AMP_SHIFT    = 2;
  localparam int ORIGIN_SHIFT = 1;
  localparam int COORD_SHIFT  = 1;
  localparam int CLAMP_SHIFT  = 3;
  localparam int SLOPE_FRAC   = 8;
  localparam int OUT_MAX      = 8191;
  localparam int MID_CODE     = 2048;
  // Converter timing: log2 of the smallest divider and of the decimation ratio.
  localparam int DIV_BASE_LOG = 3;
  localparam int DECIM_LOG    = 7;
  // Gain trim steps in percent.
  localparam logic signed [5:0] GAIN_B0 = 6'sh06;
  localparam logic signed [5:0] GAIN_B1 = 6'sh0C;
  localparam logic signed [5:0] GAIN_B2 = -6'sh18;
  typedef enum logic [1:0] {ST_IDLE, ST_DIV, ST_OUT} ipl_state_t;
endpackage

// [tb/tb_top.sv]
// Self-checking bench for the position linearizer over its register bus.
`timescale 1ns/1ps
module tb_top;
  logic        sys_clk = 1'b0;
  logic        nrst = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        coilInputA = 1'b1;
  logic        coilInputB = 1'b0;
  logic        carrierOver = 1'b0;
  logic        carrierUnder = 1'b0;
  logic [12:0] analogPositionOut;
  logic        pwmOut;
  logic        faultOut;
  logic [2:0]  pgaTrim;
  logic [5:0]  gainDeltaPct;
  logic        fbkRadiusSel;
  logic        adcClkOut;
  int          badCount = 0;
  int          comparisons = 0;
  int          cyc = 0;
  logic [31:0] rd;
  logic        er;
  int          p;
  logic [5:0]  ge;
  int          k;
  logic        q;

  ipl_linearizer dut (.sys_clk(sys_clk), .nrst(nrst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .coilInputA(coilInputA), .coilInputB(coilInputB),
    .carrierOver(carrierOver), .carrierUnder(carrierUnder),
    .analogPositionOut(analogPositionOut), .pwmOut(pwmOut), .faultOut(faultOut),
    .pgaTrim(pgaTrim), .gainDeltaPct(gainDeltaPct), .fbkRadiusSel(fbkRadiusSel),
    .adcClkOut(adcClkOut));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard; coil A sits at full scale and coil B stays silent, so
  // every converter window gives a known sine and cosine pair.
  always #2.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      badCount++;
      finalReport();
    end
  end

  task automatic finalReport();
    if (badCount == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      badCount++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // One bus transfer; the request is held until pready is sampled high.
  // A hung slave is ended by the hang guard, never by a local limit.
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  function automatic logic [31:0] ctrl(input logic [2:0] g, input logic f, input logic [1:0] r);
    return 32'(g) << ipl_pkg::CTRL_GAIN | 32'(f) << ipl_pkg::CTRL_FBK |
           32'(r) << ipl_pkg::CTRL_RATE | 32'h1 << ipl_pkg::CTRL_LOADED;
  endfunction

  // Flat curve at twice the stored y; the clamps then limit the final code.
  task automatic flat(input logic [11:0] y, input logic [9:0] lo, input logic [9:0] hi,
                      input logic [12:0] e);
    xfer(ipl_pkg::ADDR_BP1, 1'b1, {4'h0, y, 4'h0, 12'h3E8});
    xfer(ipl_pkg::ADDR_BP3, 1'b1, {4'h0, y, 4'h0, 12'h7D0});
    xfer(ipl_pkg::ADDR_BP5, 1'b1, {4'h0, y, 4'h0, 12'hBB8});
    xfer(ipl_pkg::ADDR_CLAMP, 1'b1, {6'h0, hi, 6'h0, lo});
    repeat (2300) @(posedge sys_clk);
    check(32'(analogPositionOut), 32'(e));
  endtask

  // Moves the zero point, waits for fresh samples and checks the code.
  task automatic walk(input logic [11:0] o, input logic [12:0] e);
    xfer(ipl_pkg::ADDR_ORIGIN, 1'b1, 32'(o));
    repeat (2300) @(posedge sys_clk);
    check(32'(analogPositionOut), 32'(e));
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    check(32'(fbkRadiusSel), 32'h1);
    check(32'(analogPositionOut), 32'h0);
    xfer(ipl_pkg::ADDR_CLAMP, 1'b0, 32'h0);
    check(rd, 32'h03FF0001);
    xfer(8'h40, 1'b0, 32'h0);
    check({er, rd[30:0]}, 32'h80000000);
    xfer(ipl_pkg::ADDR_STATUS, 1'b1, 32'hFFFFFFFF);
    check(32'(er), 32'h1);
    // Every trim code, each with its expected percentage step.
    for (int g = 0; g < 8; g++) begin
      xfer(ipl_pkg::ADDR_CTRL, 1'b1, ctrl(3'(g), 1'b0, 2'b00));
      repeat (3) @(posedge sys_clk);
      ge = 6'(6 * (g & 1) + 12 * ((g >> 1) & 1) - 24 * ((g >> 2) & 1));
      check(32'(pgaTrim), 32'(g));
      check(32'(gainDeltaPct), 32'(ge));
      check(32'(fbkRadiusSel), 32'h0);
    end
    for (int r = 0; r < 4; r++) begin
      xfer(ipl_pkg::ADDR_CTRL, 1'b1, ctrl(3'h0, 1'b1, 2'(r)));
      repeat (200) @(posedge sys_clk);
      p = 0;
      k = 0;
      q = adcClkOut;
      for (int n = 0; n < 300 && k < 2; n++) begin
        @(posedge sys_clk);
        if (adcClkOut === 1'b1 && q === 1'b0) k++;
        if (k == 1) p++;
        q = adcClkOut;
      end
      check(32'(p), 32'(8 << r));
    end
    xfer(ipl_pkg::ADDR_CTRL, 1'b1, ctrl(3'h0, 1'b1, 2'b00));
    check(32'(fbkRadiusSel), 32'h1);
    flat(12'hFFF, 10'd1, 10'd1023, 13'd8190);
    flat(12'hFFF, 10'd1, 10'd500, 13'd4007);
    flat(12'h000, 10'd100, 10'd1023, 13'd792);
    flat(12'h000, 10'd100, 10'd10, 13'd792);
    flat(12'd1000, 10'd1, 10'd1023, 13'd2000);
    // Either comparator alone must blank the output.
    carrierOver <= 1'b1;
    repeat (3) @(posedge sys_clk);
    check({faultOut, 18'h0, analogPositionOut}, 32'h80000000);
    carrierOver <= 1'b0;
    carrierUnder <= 1'b1;
    repeat (3) @(posedge sys_clk);
    check({faultOut, 18'h0, analogPositionOut}, 32'h80000000);
    carrierUnder <= 1'b0;
    repeat (2300) @(posedge sys_clk);
    check(32'(analogPositionOut), 32'd2000);
    // Spread points; with no amplitude allowance the origin alone sets the input.
    xfer(ipl_pkg::ADDR_BP1, 1'b1, {4'h0, 12'h000, 4'h0, 12'h3E8});
    xfer(ipl_pkg::ADDR_BP3, 1'b1, {4'h0, 12'h3E8, 4'h0, 12'h7D0});
    xfer(ipl_pkg::ADDR_BP5, 1'b1, {4'h0, 12'h7D0, 4'h0, 12'hBB8});
    xfer(ipl_pkg::ADDR_ADJ, 1'b1, {10'h000, 6'h07, 10'h000, 6'h3B});
    xfer(ipl_pkg::ADDR_SLOPE, 1'b1, {4'h0, 12'h080, 4'h0, 12'h000});
    walk(12'h1DC, 13'h03DE);
    walk(12'h5C4, 13'h0BC6);
    walk(12'h0E2, 13'h01EF);
    walk(12'h9AC, 13'h1194);
    // Full-scale coil difference is cut to four times the amplitude maximum.
    xfer(ipl_pkg::ADDR_AMPMAX, 1'b1, 32'h0000_00FF);
    walk(12'h5CE, 13'h07D0);
    // Swapped roles flip the sign of the difference; the half-band stage is on too.
    xfer(ipl_pkg::ADDR_CTRL, 1'b1, ctrl(3'h0, 1'b1, 2'b00) | 32'h1 << ipl_pkg::CTRL_SWAP
         | 32'h1 << ipl_pkg::CTRL_FIR);
    walk(12'h5CE, 13'h0FB4);
    finalReport();
  end
endmodule
